// ### hw/tors_top.sv
// 16-bit counter with low-power oscillator enable, compare-driven reset,
// prescaler and APB register file. Assumes the compare units live here as
// two small register pairs and pclk stands in for the instruction clock.
//
// The APB register port is this design's own decision.
`timescale 1ns/1ps
module tors_top (
  // Clock and reset
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  // APB slave
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [tors_pkg::ADDR_W-1:0]   paddr,
  input  wire logic [tors_pkg::DATA_W-1:0]   pwdata,
  output logic      [tors_pkg::DATA_W-1:0]   prdata,
  output logic                               pready,
  output logic                               pslverr,
  // Counter pins
  input  wire logic                          crystal_input_pin,
  input  wire logic                          external_count_clock_pin,
  output logic                               osc_amp_enable,
  // Core status and events
  input  wire logic                          sleep_mode,
  output logic                               irq,
  output logic                               wake_request,
  output logic                               special_event
);
  import tors_pkg::*;

  // Registers and their next values
  tors_ctrl_t             ctrl_q;
  logic [1:0]             intctl_q;
  logic                   ovf_flag_q;
  logic                   ovf_ie_q;
  tors_cmp_t              cmp_q [N_CMP];
  logic [CNT_W-1:0]       count_q;
  logic [CNT_W-1:0]       count_d;
  logic [PRESC_W-1:0]     presc_q;
  logic [PRESC_W-1:0]     presc_d;
  logic [DATA_W-1:0]      prdata_q;
  logic                   pslverr_q;
  logic                   special_q;

  // Bus decode
  logic                   setup_ph;
  logic                   wr_acc;
  logic                   rd_acc;
  logic                   hit;
  logic [DATA_W-1:0]      rdata_d;
  logic                   sel_intctl;
  logic                   sel_flag;
  logic                   sel_lo;
  logic                   sel_hi;
  logic                   sel_ctrl;
  logic                   sel_ie;
  logic [N_CMP-1:0]       sel_mod;
  logic [N_CMP-1:0]       sel_val;
  logic                   flag_rd_clr;

  // Counting
  logic [N_PINS-1:0]      pin_rise;
  tors_src_t              src;
  logic                   async_mode;
  logic                   raw_tick;
  logic                   presc_adv;
  logic [PRESC_W-1:0]     presc_limit;
  logic                   presc_done;
  logic                   cnt_adv;
  logic                   cnt_write;
  logic [N_CMP-1:0]       trig;
  logic                   trig_any;
  logic                   ovf_evt;
  logic                   glob_irq_en;
  logic                   instr_halt;

  assign setup_ph = psel & ~penable;
  assign wr_acc   = psel & penable & pwrite;
  assign rd_acc   = psel & penable & ~pwrite;

  // Address decode, shared by setup-phase read capture and write strobes
  always_comb begin
    sel_intctl = 1'b0;
    sel_flag   = 1'b0;
    sel_lo     = 1'b0;
    sel_hi     = 1'b0;
    sel_ctrl   = 1'b0;
    sel_ie     = 1'b0;
    sel_mod    = '0;
    sel_val    = '0;
    hit        = 1'b1;
    rdata_d    = '0;
    if (paddr == A_INTCTL) begin
      sel_intctl = 1'b1;
      rdata_d[GIE_BIT]  = intctl_q[1];
      rdata_d[PERIPHERAL_IRQ_ENABLE_BIT] = intctl_q[0];
    end else if (paddr == A_FLAG1) begin
      sel_flag = 1'b1;
      rdata_d[OVF_BIT] = ovf_flag_q;
    end else if (paddr == A_CNT_LO) begin
      sel_lo = 1'b1;
      rdata_d[7:0] = count_q[7:0];
    end else if (paddr == A_CNT_HI) begin
      sel_hi = 1'b1;
      rdata_d[7:0] = count_q[15:8];
    end else if (paddr == A_CTRL) begin
      sel_ctrl = 1'b1;
      rdata_d[7:0] = ctrl_q & CTRL_IMPL_MASK;
    end else if (paddr == A_ENABLE1) begin
      sel_ie = 1'b1;
      rdata_d[OVF_BIT] = ovf_ie_q;
    end else if (paddr == A_CMP1_MOD) begin
      sel_mod[0] = 1'b1;
      rdata_d[3:0] = cmp_q[0].compare_mode_select;
    end else if (paddr == A_CMP1_VAL) begin
      sel_val[0] = 1'b1;
      rdata_d[15:0] = cmp_q[0].compare_value_pair;
    end else if (paddr == A_CMP2_MOD) begin
      sel_mod[1] = 1'b1;
      rdata_d[3:0] = cmp_q[1].compare_mode_select;
    end else if (paddr == A_CMP2_VAL) begin
      sel_val[1] = 1'b1;
      rdata_d[15:0] = cmp_q[1].compare_value_pair;
    end else begin
      hit = 1'b0;
    end
  end

  // Zero wait states; read data is caught in setup so it comes from a flop
  assign pready  = 1'b1;
  assign prdata  = prdata_q;
  assign pslverr = pslverr_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q  <= '0;
      pslverr_q <= 1'b0;
    end else if (setup_ph) begin
      prdata_q  <= pwrite ? '0 : rdata_d;
      pslverr_q <= ~hit;
    end
  end

  // Control register; presetn is the power-on and brown-out reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= tors_ctrl_t'(CTRL_RESET);
    end else if (wr_acc && sel_ctrl) begin
      ctrl_q <= tors_ctrl_t'(pwdata[7:0] & CTRL_IMPL_MASK);
    end
  end

  // Global and peripheral interrupt enables
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      intctl_q <= INTCTL_RESET;
    end else if (wr_acc && sel_intctl) begin
      intctl_q <= {pwdata[GIE_BIT], pwdata[PERIPHERAL_IRQ_ENABLE_BIT]};
    end
  end

  // Overflow interrupt mask
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovf_ie_q <= IE_RESET;
    end else if (wr_acc && sel_ie) begin
      ovf_ie_q <= pwdata[OVF_BIT];
    end
  end

  // Compare unit mode and value registers
  // New mode or value acts from the next counter step
  genvar c;
  generate
    for (c = 0; c < N_CMP; c++) begin : g_cmp
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cmp_q[c].compare_mode_select <= CMP_MODE_RESET;
          cmp_q[c].compare_value_pair  <= CMP_VAL_RESET;
        end else begin
          if (wr_acc && sel_mod[c]) begin
            cmp_q[c].compare_mode_select <= pwdata[3:0];
          end
          if (wr_acc && sel_val[c]) begin
            cmp_q[c].compare_value_pair <= pwdata[CNT_W-1:0];
          end
        end
      end

      // Reset only where the counter is synchronous to pclk
      assign trig[c] = cnt_adv & ~async_mode
        & (cmp_q[c].compare_mode_select == CMP_MODE_SPECIAL)
        & (count_q == cmp_q[c].compare_value_pair);
    end
  endgenerate

  // Either unit may reset the shared counter
  assign trig_any = |trig;

  // Oscillator amplifier follows the enable bit only; sleep does not stop it
  assign osc_amp_enable = ctrl_q.low_power_osc_enable;

  // Pin edges after two synchronising flops
  // Pins must stay high and low one cycle or edges are missed
  tors_pin_sync u_pin_sync (
    .pclk       (pclk),
    .presetn    (presetn),
    .pins_async ({external_count_clock_pin, crystal_input_pin}),
    .rise_q     (pin_rise)
  );

  // Count source selection
  always_comb begin
    if (!ctrl_q.clock_source_select) begin
      src = SRC_INSTR;
    end else if (ctrl_q.low_power_osc_enable) begin
      src = SRC_XTAL;
    end else begin
      src = SRC_EXT;
    end
  end

  // Modelled on pclk too; only the sleep and trigger rules differ
  assign async_mode = ctrl_q.clock_source_select
                    & ctrl_q.external_sync_disable;

  always_comb begin
    case (src)
      SRC_INSTR: raw_tick = 1'b1;
      SRC_XTAL:  raw_tick = pin_rise[PIN_XTAL];
      SRC_EXT:   raw_tick = pin_rise[PIN_EXT];
      default:   raw_tick = 1'b0;
    endcase
  end

  // Instruction clock stops in sleep; external edges still feed the prescaler
  assign instr_halt = sleep_mode & (src == SRC_INSTR);
  assign presc_adv  = ctrl_q.counter_run_enable & raw_tick & ~instr_halt;

  // Limit 0, 1, 3 or 7 for 1:1 up to 1:8
  assign presc_limit = PRESC_W'((4'd1 << ctrl_q.prescale_select) - 4'd1);
  assign presc_done  = presc_adv & (presc_q == presc_limit);

  // Synchronized mode halts the counter in sleep; unsynchronized keeps going
  assign cnt_adv = presc_done & (~sleep_mode | async_mode);

  assign cnt_write = wr_acc & (sel_lo | sel_hi);

  // Prescaler count
  always_comb begin
    presc_d = presc_q;
    if (cnt_write) begin
      presc_d = '0;
    end else if (presc_done) begin
      presc_d = '0;
    end else if (presc_adv) begin
      presc_d = presc_q + PRESC_W'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc_q <= '0;
    end else begin
      presc_q <= presc_d;
    end
  end

  // Counter next value: write, then compare reset, then count
  always_comb begin
    count_d = count_q;
    if (wr_acc && sel_lo) begin
      count_d = {count_q[15:8], pwdata[7:0]};
    end else if (wr_acc && sel_hi) begin
      count_d = {pwdata[7:0], count_q[7:0]};
    end else if (trig_any) begin
      count_d = '0;
    end else if (cnt_adv) begin
      count_d = count_q + CNT_W'(1);
    end
  end

  // No reset term: holds its value through every reset
  // Unknown after power-up until software writes both bytes
  always_ff @(posedge pclk) begin
    count_q <= count_d;
  end

  // Only a counted wrap raises overflow, never a compare reset
  assign ovf_evt = cnt_adv & ~trig_any & ~cnt_write
                 & (count_q == CNT_ALL_ONES);

  // A flag set after the setup capture was not read, so it must survive
  assign flag_rd_clr = rd_acc & sel_flag & prdata_q[OVF_BIT];

  // Sticky flag; a read clears it, a new overflow in the same cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovf_flag_q <= FLAG_RESET;
    end else if (ovf_evt) begin
      ovf_flag_q <= 1'b1;
    end else if (flag_rd_clr) begin
      ovf_flag_q <= 1'b0;
    end else if (wr_acc && sel_flag) begin
      ovf_flag_q <= pwdata[OVF_BIT];
    end
  end

  // Compare event pulse for the rest of the chip
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      special_q <= 1'b0;
    end else begin
      special_q <= trig_any & ~cnt_write;
    end
  end

  assign special_event = special_q;

  // Interrupt needs both enables; wake needs only the overflow mask
  assign glob_irq_en = intctl_q[1] & intctl_q[0];
  assign irq = ovf_flag_q & ovf_ie_q & glob_irq_en;
  assign wake_request = ovf_flag_q & ovf_ie_q;

endmodule // tors_top

// ### hw/tors_pkg.sv
// Constants, field layouts and carrier types for the 16-bit counter block.
// Assumes a 100 MHz APB clock that also stands in for the instruction clock.
package tors_pkg;

  // Bus geometry
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;

  // Register indices; the byte address is four times the index
  localparam logic [7:0] IDX_INTCTL   = 8'h0b;
  localparam logic [7:0] IDX_FLAG1    = 8'h0c;
  localparam logic [7:0] IDX_CNT_LO   = 8'h0e;
  localparam logic [7:0] IDX_CNT_HI   = 8'h0f;
  localparam logic [7:0] IDX_CTRL     = 8'h10;
  localparam logic [7:0] IDX_ENABLE1  = 8'h8c;
  localparam logic [7:0] IDX_CMP1_MOD = 8'h17;
  localparam logic [7:0] IDX_CMP1_VAL = 8'h18;
  localparam logic [7:0] IDX_CMP2_MOD = 8'h1d;
  localparam logic [7:0] IDX_CMP2_VAL = 8'h1e;

  localparam logic [ADDR_W-1:0] A_INTCTL   = {2'b00, IDX_INTCTL, 2'b00};
  localparam logic [ADDR_W-1:0] A_FLAG1    = {2'b00, IDX_FLAG1, 2'b00};
  localparam logic [ADDR_W-1:0] A_CNT_LO   = {2'b00, IDX_CNT_LO, 2'b00};
  localparam logic [ADDR_W-1:0] A_CNT_HI   = {2'b00, IDX_CNT_HI, 2'b00};
  localparam logic [ADDR_W-1:0] A_CTRL     = {2'b00, IDX_CTRL, 2'b00};
  localparam logic [ADDR_W-1:0] A_ENABLE1  = {2'b00, IDX_ENABLE1, 2'b00};
  localparam logic [ADDR_W-1:0] A_CMP1_MOD = {2'b00, IDX_CMP1_MOD, 2'b00};
  localparam logic [ADDR_W-1:0] A_CMP1_VAL = {2'b00, IDX_CMP1_VAL, 2'b00};
  localparam logic [ADDR_W-1:0] A_CMP2_MOD = {2'b00, IDX_CMP2_MOD, 2'b00};
  localparam logic [ADDR_W-1:0] A_CMP2_VAL = {2'b00, IDX_CMP2_VAL, 2'b00};

  // Field positions
  localparam int unsigned CTRL_RUN_BIT  = 0;
  localparam int unsigned CTRL_CS_BIT   = 1;
  localparam int unsigned CTRL_SYNC_BIT = 2;
  localparam int unsigned CTRL_OSC_BIT  = 3;
  localparam int unsigned CTRL_PS_LSB   = 4;
  localparam int unsigned OVF_BIT       = 0;
  localparam int unsigned GIE_BIT       = 7;
  localparam int unsigned PERIPHERAL_IRQ_ENABLE_BIT      = 6;

  // Implemented bits and reset values
  localparam logic [7:0]  CTRL_IMPL_MASK = 8'h3f;
  localparam logic [7:0]  CTRL_RESET     = 8'h00;
  localparam logic [1:0]  INTCTL_RESET   = 2'h0;
  localparam logic        FLAG_RESET     = 1'b0;
  localparam logic        IE_RESET       = 1'b0;
  localparam logic [3:0]  CMP_MODE_RESET = 4'h0;
  localparam logic [15:0] CMP_VAL_RESET  = 16'h0000;

  // Compare mode that resets the counter
  localparam logic [3:0]  CMP_MODE_SPECIAL = 4'hb;

  // Counter and prescaler
  localparam int unsigned CNT_W   = 16;
  localparam int unsigned PRESC_W = 3;
  localparam logic [CNT_W-1:0] CNT_ALL_ONES = 16'hffff;
  localparam int unsigned N_CMP   = 2;

  // Pin inputs: index of each in the synchroniser
  localparam int unsigned N_PINS  = 2;
  localparam int unsigned PIN_XTAL = 0;
  localparam int unsigned PIN_EXT  = 1;

  typedef struct packed {
    logic [1:0] unused;
    logic [1:0] prescale_select;
    logic       low_power_osc_enable;
    logic       external_sync_disable;
    logic       clock_source_select;
    logic       counter_run_enable;
  } tors_ctrl_t;

  typedef struct packed {
    logic [3:0]       compare_mode_select;
    logic [CNT_W-1:0] compare_value_pair;
  } tors_cmp_t;

  typedef enum logic [1:0] {
    SRC_INSTR = 2'b00,
    SRC_XTAL  = 2'b01,
    SRC_EXT   = 2'b10
  } tors_src_t;

endpackage

// ### hw/tors_pin_sync.sv
// Two-stage synchroniser with rising-edge pulse for each counter pin.
// Assumes pins are asynchronous to pclk and slower than half its rate.
`timescale 1ns/1ps
module tors_pin_sync (
  // Clock and reset
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  // Pins and edge pulses
  input  wire logic [tors_pkg::N_PINS-1:0] pins_async,
  output logic      [tors_pkg::N_PINS-1:0] rise_q
);
  import tors_pkg::*;

  genvar g;
  generate
    for (g = 0; g < N_PINS; g++) begin : g_pin
      logic meta_q;
      logic sync_q;
      logic last_q;
      // First stage feeds only the second
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          meta_q <= 1'b0;
          sync_q <= 1'b0;
          last_q <= 1'b0;
          rise_q[g] <= 1'b0;
        end else begin
          meta_q <= pins_async[g];
          sync_q <= meta_q;
          last_q <= sync_q;
          rise_q[g] <= sync_q & ~last_q;
        end
      end
    end
  endgenerate

endmodule // tors_pin_sync

// ### test/tors_properties.sv
// Port-level checks for the 16-bit counter block.
// Assumes one pclk domain with presetn as its asynchronous reset.
`timescale 1ns/1ps
module tors_properties (
  // Clock and reset
  input wire logic                        pclk,
  input wire logic                        presetn,
  // APB
  input wire logic                        psel,
  input wire logic                        penable,
  input wire logic                        pwrite,
  input wire logic [tors_pkg::ADDR_W-1:0] paddr,
  input wire logic [tors_pkg::DATA_W-1:0] pwdata,
  input wire logic [tors_pkg::DATA_W-1:0] prdata,
  input wire logic                        pslverr,
  // Status
  input wire logic                        osc_amp_enable,
  input wire logic                        irq,
  input wire logic                        wake_request,
  input wire logic                        special_event
);
  import tors_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Decoded bus cycles
  wire ctrl_wr = psel && penable && pwrite && paddr == A_CTRL;
  wire ctrl_rd = psel && penable && !pwrite && paddr == A_CTRL;
  wire cnt_wr  = psel && penable && pwrite &&
                 (paddr == A_CNT_LO || paddr == A_CNT_HI);
  wire clr_acc = psel && (paddr == A_FLAG1 || paddr == A_ENABLE1);

  sequence s_ctrl_wr;
    ctrl_wr;
  endsequence
  sequence s_no_flag2;
    !wake_request ##1 !wake_request;
  endsequence

  property p_osc_follow;
    s_ctrl_wr |=> osc_amp_enable == $past(pwdata[CTRL_OSC_BIT]);
  endproperty
  a_osc_follow: assert property (p_osc_follow)
    else $error("osc enable differs from written control bit");

  // Sleep must never touch the oscillator enable
  property p_osc_only_ctrl;
    $changed(osc_amp_enable) |-> $past(ctrl_wr);
  endproperty
  a_osc_only_ctrl: assert property (p_osc_only_ctrl)
    else $error("osc enable changed without a control write");

  property p_ctrl_rsv;
    ctrl_rd |-> prdata[7:6] == 2'b00 && !pslverr;
  endproperty
  a_ctrl_rsv: assert property (p_ctrl_rsv)
    else $error("control upper bits not zero on read");

  property p_por_quiet;
    $rose(presetn) |-> !osc_amp_enable && !irq && !wake_request;
  endproperty
  a_por_quiet: assert property (p_por_quiet)
    else $error("outputs not idle after power-on reset");

  // Watch two cycles, the flag may land one edge late
  property p_sev_noflag;
    special_event && !$past(wake_request) && !$past(psel) && !psel
      |-> s_no_flag2;
  endproperty
  a_sev_noflag: assert property (p_sev_noflag)
    else $error("compare reset raised the overflow flag");

  property p_flag_sticky;
    $fell(wake_request) |-> $past(clr_acc);
  endproperty
  a_flag_sticky: assert property (p_flag_sticky)
    else $error("overflow flag dropped without a clear");

  property p_irq_flag;
    irq |-> wake_request;
  endproperty
  a_irq_flag: assert property (p_irq_flag)
    else $error("irq high without overflow wake request");

  property p_write_wins;
    cnt_wr |=> !special_event;
  endproperty
  a_write_wins: assert property (p_write_wins)
    else $error("compare reset fired during a counter write");
endmodule // tors_properties

// ### test/tors_osc_model.sv
// Behavioural crystal and external clock source, 125 ns period.
// Assumes the bench raises go only for a burst of count edges.
`timescale 1ns/1ps
module tors_osc_model (
  // Control
  input  wire logic amp_enable,
  input  wire logic go,
  // Pins
  output logic      crystal_input_pin,
  output logic      external_count_clock_pin,
  output int        pulses
);
  initial begin
    crystal_input_pin = 1'b0;
    external_count_clock_pin = 1'b0;
    pulses = 0;
  end
  // Pins stand still low between bursts; no sleep input, keeps running
  always begin
    wait (go);
    external_count_clock_pin = 1'b1;
    crystal_input_pin = amp_enable;
    pulses++;
    #62.5;
    external_count_clock_pin = 1'b0;
    crystal_input_pin = 1'b0;
    #62.5;
  end
endmodule // tors_osc_model

// ### test/tb.sv
// Self-checking bench for the counter block over APB.
// Assumes zero-wait APB slave and a behavioural clock source.
`timescale 1ns/1ps
module tb;
  import tors_pkg::*;
  logic              pclk = 1'b0;
  logic              presetn = 1'b0;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0;
  logic [DATA_W-1:0] prdata;
  logic [DATA_W-1:0] rd;
  logic              pready, pslverr, err, xtal, extc, osc_en;
  logic              sleep_mode = 1'b0;
  logic              go = 1'b0;
  logic              irq, wake, sev;
  int                n_pulse;
  int                n_errors = 0;
  int                samples_checked = 0;

  always #5 pclk = ~pclk;

  tors_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .crystal_input_pin(xtal), .external_count_clock_pin(extc),
    .osc_amp_enable(osc_en), .sleep_mode(sleep_mode), .irq(irq),
    .wake_request(wake), .special_event(sev));

  tors_osc_model u_osc (.amp_enable(osc_en), .go(go),
    .crystal_input_pin(xtal), .external_count_clock_pin(extc),
    .pulses(n_pulse));

  task automatic close_out();
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wt(int n);
    repeat (n) @(posedge pclk);
  endtask

  // One APB transfer; waits for pready under a bound
  task automatic apb(logic [ADDR_W-1:0] a, logic w, logic [15:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) begin
      n_errors++;
      close_out();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask

  task automatic wait_sev(output int k);
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (sev !== 1'b1 && k < 100);
    if (k >= 100) begin
      n_errors++;
      close_out();
    end
  endtask

  task automatic t_regs();
    apb(A_CTRL, 0, 0);
    chk("ctrl reset", rd, 0);
    apb(A_CTRL, 1, 16'h00ff);
    apb(A_CTRL, 0, 0);
    chk("ctrl upper", rd, 32'h3f);
    chk("osc enable", osc_en, 1);
    apb(A_CTRL, 1, 0);
    chk("osc off", osc_en, 0);
    apb(12'h000, 1, 16'h0055);
    apb(12'h000, 0, 0);
    chk("unmapped err", err, 1);
    chk("unmapped data", rd, 0);
  endtask

  task automatic t_timer();
    logic [7:0] v;
    apb(A_CNT_LO, 1, 16'h0010);
    apb(A_CNT_HI, 1, 16'h0020);
    apb(A_CNT_LO, 0, 0);
    chk("cnt lo", rd, 32'h10);
    apb(A_CNT_HI, 0, 0);
    chk("cnt hi", rd, 32'h20);
    // Sync bit set on the second pass must not matter
    for (int m = 0; m < 2; m++) begin
      apb(A_CTRL, 1, m ? 16'h0005 : 16'h0001);
      apb(A_CNT_LO, 0, 0);
      v = rd[7:0];
      apb(A_CNT_LO, 0, 0);
      chk("timer step", rd[7:0], 8'(v + 8'd3));
    end
  endtask

  task automatic t_presc();
    apb(A_CTRL, 1, 16'h0031);
    for (int i = 0; i < 8; i++) begin
      wt(i);
      apb(A_CNT_LO, 1, 16'h0040);
      apb(A_CNT_LO, 0, 0);
      chk("prescale clear", rd, 32'h40);
    end
  endtask

  task automatic t_ovf();
    apb(A_CTRL, 1, 0);
    apb(A_CNT_HI, 1, 16'h00ff);
    apb(A_CNT_LO, 1, 16'h00f0);
    apb(A_ENABLE1, 1, 1);
    apb(A_INTCTL, 1, 16'h00c0);
    apb(A_CTRL, 1, 16'h0001);
    wt(30);
    chk("irq set", irq, 1);
    apb(A_ENABLE1, 1, 0);
    chk("irq masked", irq, 0);
    chk("wake masked", wake, 0);
    apb(A_ENABLE1, 1, 1);
    chk("flag sticky", irq, 1);
    apb(A_FLAG1, 0, 0);
    chk("flag read", rd, 1);
    apb(A_FLAG1, 0, 0);
    chk("flag cleared", rd, 0);
    chk("irq cleared", irq, 0);
  endtask

  task automatic t_cmp();
    int k;
    for (int u = 0; u < 2; u++) begin
      apb(A_CTRL, 1, 0);
      apb(A_CNT_HI, 1, 0);
      apb(A_CNT_LO, 1, 0);
      apb(u ? A_CMP2_VAL : A_CMP1_VAL, 1, 16'h0004);
      apb(u ? A_CMP2_MOD : A_CMP1_MOD, 1, {12'h0, CMP_MODE_SPECIAL});
      apb(A_CTRL, 1, 16'h0001);
      wait_sev(k);
      wait_sev(k);
      chk("period", k, 5);
      apb(A_CNT_HI, 0, 0);
      chk("cnt hi", rd, 0);
      // Match at all ones must reset without raising overflow
      apb(A_CTRL, 1, 0);
      apb(A_CNT_HI, 1, 16'h00ff);
      apb(A_CNT_LO, 1, 16'h00fa);
      apb(u ? A_CMP2_VAL : A_CMP1_VAL, 1, 16'hffff);
      apb(A_CTRL, 1, 16'h0001);
      wait_sev(k);
      chk("wrap trig", k, 7);
      wt(2);
      chk("no flag", wake, 0);
      // Write lands on the match edge, three edges after run starts
      apb(A_CTRL, 1, 0);
      apb(A_CNT_HI, 1, 0);
      apb(A_CNT_LO, 1, 16'h0020);
      apb(u ? A_CMP2_VAL : A_CMP1_VAL, 1, 16'h0022);
      apb(A_CTRL, 1, 16'h0001);
      apb(A_CNT_LO, 1, 16'h0020);
      apb(A_CNT_LO, 0, 0);
      chk("write wins", rd, 32'h21);
      apb(u ? A_CMP2_MOD : A_CMP1_MOD, 1, 0);
    end
  endtask

  // Modes: sync ext, sync crystal, unsync crystal in sleep, sync in sleep
  task automatic t_ext();
    logic [7:0] cfg [4] = '{8'h03, 8'h0b, 8'h0f, 8'h03};
    int n0;
    for (int i = 0; i < 4; i++) begin
      apb(A_CTRL, 1, {8'h0, cfg[i]});
      @(posedge pclk);
      sleep_mode <= (i >= 2);
      wt(40);
      chk("osc in sleep", osc_en, cfg[i][3]);
      apb(A_CNT_HI, 1, 0);
      apb(A_CNT_LO, 1, 0);
      n0 = n_pulse;
      @(posedge pclk);
      go <= 1'b1;
      wt(100);
      go <= 1'b0;
      wt(30);
      apb(A_CNT_LO, 0, 0);
      chk("ext count", rd, i == 3 ? 0 : n_pulse - n0);
    end
    @(posedge pclk);
    sleep_mode <= 1'b0;
  endtask

  task automatic t_por();
    apb(A_CTRL, 1, 0);
    apb(A_CNT_HI, 1, 16'h005a);
    apb(A_CNT_LO, 1, 16'h00a5);
    apb(A_CTRL, 1, 16'h000e);
    @(posedge pclk);
    presetn <= 1'b0;
    wt(6);
    presetn <= 1'b1;
    apb(A_CTRL, 0, 0);
    chk("ctrl after por", rd, 0);
    chk("osc after por", osc_en, 0);
    apb(A_CNT_HI, 0, 0);
    chk("hi kept", rd, 32'h5a);
    apb(A_CNT_LO, 0, 0);
    chk("lo kept", rd, 32'ha5);
  endtask

  initial begin
    wt(6);
    presetn <= 1'b1;
    t_regs();
    t_timer();
    t_presc();
    t_ovf();
    t_cmp();
    t_ext();
    t_por();
    close_out();
  end
endmodule // tb

bind tors_top tors_properties u_props (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pslverr(pslverr),
  .osc_amp_enable(osc_amp_enable), .irq(irq),
  .wake_request(wake_request), .special_event(special_event));
